// [tb.sv]
// Self-checking bench for the VRAM host sequencer
`timescale 1ns/10ps
module tb;
  logic        clk, rst_n;
  logic [3:0]  s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic        rasN, casN, xferOeN, writeMaskStrobeN, functionSelectPin;
  logic        regLoadQual, dataMaskPinsOeN, halfSelectStatus, badCode;
  logic [8:0]  addrOut, colCas;
  logic [15:0] dataMaskPinsOut, dataCas;
  logic [3:0]  lastOp;
  logic [7:0]  nCyc;
  logic [31:0] st;
  int          bad_count, n_tests;
  vdwss_host dut (.clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .rasN, .casN, .xferOeN, .writeMaskStrobeN,
    .functionSelectPin, .regLoadQual, .addrOut, .dataMaskPinsOut,
    .dataMaskPinsOeN, .halfSelectStatus);
  vdwss_dev_model dev (.rasN, .casN, .xferOeN, .writeMaskStrobeN,
    .functionSelectPin, .regLoadQual, .addrOut, .dataMaskPinsOut,
    .halfSelectStatus, .lastOp, .colCas, .dataCas, .nCyc, .badCode);
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    s_rready <= 1'b0;
  endtask
  // Polls busy so that no command is dropped by the host
  task automatic run(input logic [3:0] op, input logic [17:0] adr);
    int n;
    n = 0;
    axw(vdwss_pkg::ADDR_OFF, {14'h0, adr});
    axw(vdwss_pkg::DATA_OFF, 32'h0000_5aa5);
    axw(vdwss_pkg::CMD_OFF, {28'h0, op});
    do begin
      axr(vdwss_pkg::STATUS_OFF, st);
      n++;
    end while (st[vdwss_pkg::ST_BUSY] !== 1'b0 && n < 200);
    // A cycle that never ends is a failure, not a silent skip
    if (st[vdwss_pkg::ST_BUSY] !== 1'b0) begin
      bad_count++;
      $display("ERROR %0t busy never cleared", $time);
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every op once; row 0x17f carries stop code 0111 with noise bits
  task automatic t_all_ops;
    logic [7:0] c;
    for (int op = 0; op <= vdwss_pkg::OP_LAST; op++) begin
      c = nCyc;
      run(4'(op), {9'h17f, 9'h12d});
      check({24'h0, nCyc - c}, 32'h1);
      check({28'h0, lastOp}, 32'(op));
      if (op == 5 || op == 6) begin
        check({23'h0, colCas}, 32'h128);
        check({16'h0, dataCas}, 32'h5aa5);
      end
    end
    check({31'h0, badCode}, 32'h0);
    check({29'h0, st[3:1]}, 32'h6);
  endtask
  task automatic t_reset_all;
    run(vdwss_pkg::OP_RESET_ALL, 18'h0);
    check({31'h0, st[vdwss_pkg::ST_MASKLD]}, 32'h0);
    run(vdwss_pkg::OP_READ_XFER, 18'h0);
    check({31'h0, st[vdwss_pkg::ST_HALF]}, 32'h0);
  endtask
  // Inhibited code must be refused before any strobe moves
  task automatic t_bad_code;
    logic [7:0] c;
    c = nCyc;
    run(vdwss_pkg::OP_STOP_SET, {9'h050, 9'h0});
    check({24'h0, nCyc - c}, 32'h0);
    check({31'h0, st[vdwss_pkg::ST_BADCODE]}, 32'h1);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // About fifteen commands of some thirty cycles each; ample margin
  initial begin
    #(25 * 20000);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    bad_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    s_awaddr = 4'h0;
    s_araddr = 4'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'hf;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_all_ops();
    t_reset_all();
    t_bad_code();
    tally_and_finish();
  end
endmodule

// [vdwss_dev_model.sv]
// Behavioural model of the video DRAM decode side
`timescale 1ns/10ps
module vdwss_dev_model (
  input  wire logic        rasN,
  input  wire logic        casN,
  input  wire logic        xferOeN,
  input  wire logic        writeMaskStrobeN,
  input  wire logic        functionSelectPin,
  input  wire logic        regLoadQual,
  input  wire logic [8:0]  addrOut,
  input  wire logic [15:0] dataMaskPinsOut,
  output logic             halfSelectStatus,
  output logic [3:0]       lastOp,
  output logic [8:0]       colCas,
  output logic [15:0]      dataCas,
  output logic [7:0]       nCyc,
  output logic             badCode
);
  logic       cbr;
  logic       xfer;
  logic       wm;
  logic       fs;
  logic       q;
  logic       fsCas;
  logic [3:0] stopPend;
  logic [3:0] stopAct;
  initial begin
    halfSelectStatus = 1'b0;
    nCyc = 8'h00;
    badCode = 1'b0;
  end
  // ----------------------------------------
  // Pin levels latched at the strobe edges
  // ----------------------------------------
  // Any variant is accepted, so self refresh needs no extra path
  always @(negedge rasN) begin
    cbr  = !casN;
    xfer = !xferOeN;
    wm   = writeMaskStrobeN;
    fs   = functionSelectPin;
    q    = regLoadQual;
    if (cbr && !fs) begin
      stopPend = 4'hf;
      stopAct  = 4'hf;
    end
    if (cbr && fs && !wm) begin
      stopPend = addrOut[7:4];
      if (!(addrOut[7:4] inside {4'hf, 4'h7, 4'h3, 4'h1, 4'h0}))
        badCode = 1'b1;
    end
    if (xfer && fs)
      stopAct = stopPend;
  end
  always @(negedge casN) begin
    fsCas   = functionSelectPin;
    colCas  = addrOut;
    dataCas = dataMaskPinsOut;
    if (!rasN && xfer && !fs)
      halfSelectStatus = addrOut[8];
  end
  always @(posedge rasN) begin
    nCyc = nCyc + 8'h01;
    if (cbr)
      lastOp = !fs ? 4'h0 : (!wm ? 4'h1 : 4'h2);
    else if (xfer)
      lastOp = fs ? 4'ha : 4'h9;
    else if (q)
      lastOp = fsCas ? 4'h8 : 4'h7;
    else
      lastOp = wm ? (fsCas ? 4'h5 : 4'h3) : (fsCas ? 4'h6 : 4'h4);
  end
endmodule

// [vdwss_host.sv]
// VRAM host: AXI4-Lite register slave that sequences strobe cycles
`timescale 1ns/10ps
// What this block and the device do
// R1: Device wraps to other half tap address
// R2: Stop set: strobe low, select high, CBR
// R3: Stop point waits for a split transfer
// R4: Stop point ignored by ordinary transfers
// R5: Early split jumps at partition boundary
// R6: Reset-all: CBR with select low
// R7: Stop code on row bits 7..4
// R8: Strobe picks mask, select picks block
// R9: Qualifier high picks mask/colour load
// R10: Loaded mask overrides data pins
// R11: Unloaded mask comes from data pins
// R12: Block write column mask per byte
// R13: Block write ignores column bits 0..2
// R14: CBR variant chosen at RAS fall
// R15: Self refresh accepts any variant
// R16: Reset-all clears mask and stop
// R17: Half-select status tracks shifting half
// R18: Never program an inhibited stop code
module vdwss_host #(
  parameter int PHASE = vdwss_pkg::PHASE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [3:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             rasN,
  output logic             casN,
  output logic             xferOeN,
  output logic             writeMaskStrobeN,
  output logic             functionSelectPin,
  output logic             regLoadQual,
  output logic [8:0]       addrOut,
  output logic [15:0]      dataMaskPinsOut,
  output logic             dataMaskPinsOeN,
  input  wire logic        halfSelectStatus
);
  if (PHASE < 1 || PHASE > 255) begin : g_bad_phase
    $error("PHASE out of range");
  end
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [3:0]  awAddr_reg;
  logic        awHave_reg;
  logic [31:0] wData_reg;
  logic        wHave_reg;
  logic [17:0] addr_reg;
  logic [15:0] data_reg;
  logic [3:0]  op_reg;
  logic        start_reg;
  logic        badCode_reg;
  logic        maskLoaded_reg;
  vdwss_pkg::vdwss_state_t state_reg;
  function automatic logic stopCodeOk(input logic [3:0] c);
    return c == vdwss_pkg::STOP_1X256 || c == vdwss_pkg::STOP_2X128 ||
           c == vdwss_pkg::STOP_4X64 || c == vdwss_pkg::STOP_8X32 ||
           c == vdwss_pkg::STOP_16X16;
  endfunction
  assign s_awready = !awHave_reg && !s_bvalid;
  assign s_wready  = !wHave_reg && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign s_bresp   = 2'h0;
  assign s_rresp   = 2'h0;
  wire busy = state_reg != vdwss_pkg::VDWSS_IDLE || start_reg;
  wire doWrite = awHave_reg && wHave_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wHave_reg  <= 1'b0;
      wData_reg  <= 32'h0;
      s_bvalid   <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_wdata;
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg  <= 1'b0;
        s_bvalid   <= 1'b1;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // Writes while a cycle runs are dropped so pins never change mid-cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg    <= 18'h0;
      data_reg    <= 16'h0;
      op_reg      <= 4'h0;
      start_reg   <= 1'b0;
      badCode_reg <= 1'b0;
    end else begin
      if (state_reg == vdwss_pkg::VDWSS_PRE) start_reg <= 1'b0;
      if (doWrite && !busy) begin
        case (awAddr_reg)
          vdwss_pkg::ADDR_OFF: addr_reg <= wData_reg[17:0];
          vdwss_pkg::DATA_OFF: data_reg <= wData_reg[15:0];
          vdwss_pkg::CMD_OFF: begin
            // Inhibited row codes (row sits in [17:9]) are never driven out
            if (wData_reg[3:0] == vdwss_pkg::OP_STOP_SET &&
                !stopCodeOk(addr_reg[9 + vdwss_pkg::STOP_LSB +: 4])) begin
              badCode_reg <= 1'b1; // see R18
            end else if (int'(wData_reg[3:0]) <= vdwss_pkg::OP_LAST) begin
              op_reg      <= wData_reg[3:0];
              start_reg   <= 1'b1;
              badCode_reg <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      case (s_araddr)
        vdwss_pkg::ADDR_OFF:   s_rdata <= {14'h0, addr_reg};
        vdwss_pkg::DATA_OFF:   s_rdata <= {16'h0, data_reg};
        vdwss_pkg::CMD_OFF:    s_rdata <= {28'h0, op_reg};
        vdwss_pkg::STATUS_OFF: s_rdata <= {28'h0, halfSelectStatus,
                                           maskLoaded_reg, badCode_reg,
                                           busy}; // see R17
        default:               s_rdata <= 32'h0;
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  logic [7:0] cnt_reg;
  wire isCbr = op_reg <= vdwss_pkg::OP_REFRESH_ONLY;
  wire isXfer = op_reg >= vdwss_pkg::OP_READ_XFER;
  wire isLoad = op_reg == vdwss_pkg::OP_LOAD_MASK ||
                op_reg == vdwss_pkg::OP_LOAD_COLOR;
  wire isMasked = op_reg == vdwss_pkg::OP_MASK_WRITE ||
                  op_reg == vdwss_pkg::OP_MBLOCK_WRITE;
  wire isBlock = op_reg == vdwss_pkg::OP_BLOCK_WRITE ||
                 op_reg == vdwss_pkg::OP_MBLOCK_WRITE;
  wire phaseDone = cnt_reg == 8'(PHASE - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= vdwss_pkg::VDWSS_IDLE;
      cnt_reg   <= 8'h0;
    end else begin
      cnt_reg <= phaseDone ? 8'h0 : cnt_reg + 8'h1;
      case (state_reg)
        vdwss_pkg::VDWSS_IDLE: begin
          cnt_reg <= 8'h0;
          if (start_reg) state_reg <= vdwss_pkg::VDWSS_PRE;
        end
        vdwss_pkg::VDWSS_PRE:  if (phaseDone) state_reg <= vdwss_pkg::VDWSS_RAS;
        vdwss_pkg::VDWSS_RAS:  if (phaseDone) state_reg <= vdwss_pkg::VDWSS_CAS;
        vdwss_pkg::VDWSS_CAS:  if (phaseDone) state_reg <= vdwss_pkg::VDWSS_HOLD;
        vdwss_pkg::VDWSS_HOLD: if (phaseDone) state_reg <= vdwss_pkg::VDWSS_END;
        vdwss_pkg::VDWSS_END:  if (phaseDone) state_reg <= vdwss_pkg::VDWSS_IDLE;
        default:               state_reg <= vdwss_pkg::VDWSS_IDLE;
      endcase
    end
  end
  // Pins change at phase entry; CBR drops CAS in PRE, others drop RAS first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rasN              <= 1'b1;
      casN              <= 1'b1;
      xferOeN           <= 1'b1;
      writeMaskStrobeN  <= 1'b1;
      functionSelectPin <= 1'b0;
      regLoadQual       <= 1'b0;
      addrOut           <= 9'h0;
      dataMaskPinsOut   <= 16'h0;
      dataMaskPinsOeN   <= 1'b1;
    end else begin
      case (state_reg)
        vdwss_pkg::VDWSS_PRE: begin
          casN    <= !isCbr;
          xferOeN <= !isXfer;
          addrOut <= addr_reg[17:9];
          if (isCbr) begin
            functionSelectPin <= op_reg != vdwss_pkg::OP_RESET_ALL; // see R6
            writeMaskStrobeN  <= op_reg != vdwss_pkg::OP_STOP_SET; // see R14
          end else if (isXfer) begin
            functionSelectPin <= op_reg == vdwss_pkg::OP_SPLIT_XFER; // see R3
            writeMaskStrobeN  <= 1'b1; // see R4
          end else begin
            functionSelectPin <= 1'b0;
            writeMaskStrobeN  <= !isMasked; // see R8
          end
          regLoadQual     <= isLoad; // see R9
          // New mask on data pins at RAS fall; loaded mask makes it moot
          dataMaskPinsOut <= data_reg; // see R11
          dataMaskPinsOeN <= !isMasked; // see R10
        end
        vdwss_pkg::VDWSS_RAS: begin
          rasN <= 1'b0; // see R2
          if (phaseDone) begin
            if (!isCbr) begin
              // Block write: column bits 0..2 are don't care
              addrOut <= isBlock ? {addr_reg[8:3], 3'h0}
                                 : addr_reg[8:0]; // see R13
              functionSelectPin <= isBlock ||
                                   op_reg == vdwss_pkg::OP_LOAD_COLOR;
              writeMaskStrobeN  <= isXfer;
              dataMaskPinsOut   <= data_reg; // see R12
              dataMaskPinsOeN   <= isXfer;
            end
          end
        end
        vdwss_pkg::VDWSS_CAS: if (!isCbr) casN <= 1'b0;
        vdwss_pkg::VDWSS_HOLD: begin
          rasN    <= 1'b1;
          xferOeN <= 1'b1;
        end
        vdwss_pkg::VDWSS_END: begin
          casN              <= 1'b1;
          writeMaskStrobeN  <= 1'b1;
          regLoadQual       <= 1'b0;
          dataMaskPinsOeN   <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  // Host mirror of the device's mask mode; reset-all returns to new mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maskLoaded_reg <= 1'b0;
    end else if (state_reg == vdwss_pkg::VDWSS_RAS && phaseDone) begin
      if (op_reg == vdwss_pkg::OP_LOAD_MASK) maskLoaded_reg <= 1'b1;
      else if (op_reg == vdwss_pkg::OP_RESET_ALL)
        maskLoaded_reg <= 1'b0; // see R16
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cbr_cas_first: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rasN) |-> (isCbr == !casN)) // see R14
    else $error("CAS order wrong at RAS fall");
  a_stop_set_pins: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(rasN) && op_reg == vdwss_pkg::OP_STOP_SET) |->
      (!writeMaskStrobeN && functionSelectPin &&
       stopCodeOk(addrOut[7:4]))) // see R2
    else $error("Stop set pins wrong");
  a_reset_all_sel: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(rasN) && op_reg == vdwss_pkg::OP_RESET_ALL) |->
      !functionSelectPin) // see R6
    else $error("Reset-all select high");
  a_xfer_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(rasN) && isXfer) |-> (writeMaskStrobeN && !xferOeN &&
      functionSelectPin == (op_reg == vdwss_pkg::OP_SPLIT_XFER))) // see R3
    else $error("Transfer pins wrong");
  a_mask_pick: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(rasN) && !isCbr && !isXfer) |->
      (writeMaskStrobeN == !isMasked && regLoadQual == isLoad)) // see R8
    else $error("Write kind pins wrong");
  a_block_column: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(casN) && isBlock) |->
      (addrOut[2:0] == 3'h0 && functionSelectPin)) // see R13
    else $error("Block column wrong");
  a_new_mask_out: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(rasN) && isMasked) |->
      (!dataMaskPinsOeN && dataMaskPinsOut == data_reg)) // see R11
    else $error("Mask not driven at RAS fall");
  a_cycle_length: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rasN) |-> ##[1:300] $rose(rasN)) // see R15
    else $error("RAS low too long");
  a_reset_unload: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(rasN) && op_reg == vdwss_pkg::OP_RESET_ALL) |->
      ##[1:300] !maskLoaded_reg) // see R16
    else $error("Mask mode not cleared");
endmodule

// [vdwss_pkg.sv]
// Package: command codes, register offsets and pin timing for the VRAM host
package vdwss_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [3:0] CMD_OFF    = 4'h0;
  localparam logic [3:0] ADDR_OFF   = 4'h4;
  localparam logic [3:0] DATA_OFF   = 4'h8;
  localparam logic [3:0] STATUS_OFF = 4'hc;
  // Command codes in CMD[3:0]; write to CMD starts a cycle
  localparam logic [3:0] OP_RESET_ALL    = 4'h0;
  localparam logic [3:0] OP_STOP_SET     = 4'h1;
  localparam logic [3:0] OP_REFRESH_ONLY = 4'h2;
  localparam logic [3:0] OP_WRITE        = 4'h3;
  localparam logic [3:0] OP_MASK_WRITE   = 4'h4;
  localparam logic [3:0] OP_BLOCK_WRITE  = 4'h5;
  localparam logic [3:0] OP_MBLOCK_WRITE = 4'h6;
  localparam logic [3:0] OP_LOAD_MASK    = 4'h7;
  localparam logic [3:0] OP_LOAD_COLOR   = 4'h8;
  localparam logic [3:0] OP_READ_XFER    = 4'h9;
  localparam logic [3:0] OP_SPLIT_XFER   = 4'ha;
  localparam int OP_LAST = 10;
  // Stop point codes on row address bits 7..4
  localparam logic [3:0] STOP_1X256 = 4'hf;
  localparam logic [3:0] STOP_2X128 = 4'h7;
  localparam logic [3:0] STOP_4X64  = 4'h3;
  localparam logic [3:0] STOP_8X32  = 4'h1;
  localparam logic [3:0] STOP_16X16 = 4'h0;
  localparam int STOP_LSB = 4;
  // Status bits
  localparam int ST_BUSY    = 0;
  localparam int ST_BADCODE = 1;
  localparam int ST_MASKLD  = 2;
  localparam int ST_HALF    = 3;
  // Each strobe phase lasts at least this long
  localparam int PHASE_NS = 50;
  localparam int CLK_NS   = 25;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    VDWSS_IDLE = 3'b000,
    VDWSS_PRE  = 3'b001,
    VDWSS_RAS  = 3'b011,
    VDWSS_CAS  = 3'b010,
    VDWSS_HOLD = 3'b110,
    VDWSS_END  = 3'b111
  } vdwss_state_t;
endpackage
